// ===== srtc_device.sv
// Device end: serial slave of the clock chip register file
`timescale 1ns/1ps
// How it works
// (R01) Input bit taken on serial clock rise
// (R02) Output bit moves after serial clock fall
// (R03) Master uses mode 0,0 or 1,1 only
// (R04) Select high: ignore inputs, output released
// (R05) Master lowers select before first transfer
// (R06) First rise after select samples, MSB first
// (R07) First bit one writes, zero reads
// (R08) Bits two to eight form address
// (R09) Address bit six is ignored
// (R10) One clock per bit, eight-bit groups
// (R11) Pointer advances after each data byte
// (R12) Pointer wraps from top to zero
// (R13) Output released until full byte ready
// (R14) Clock address access freezes user copy
// (R15) Deselect or non-clock address resumes copy
// (R16) Supply fail aborts access, clears pointer
// (R17) Reset output low through recovery time
// (R18) Selection accepted once supply is good
// (R19) Clock write resets divider, loads time
// (R20) Each select restarts bit counting
module srtc_device #(
	parameter int unsigned RECOVER = srtc_pkg::RECOVER_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Serial link
	srtc_if.device link,
	// Supply monitor: high while supply is above threshold
	input wire logic supplyOk,
	// Register file port
	output logic [srtc_pkg::ADDR_W-1:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrStb,
	output logic regRdStb,
	input wire logic [7:0] regRdData,
	// Timekeeping control
	output logic freezeCopy,
	output logic clockLoad
);
	import srtc_pkg::*;

	// Synchroniser stages for pins
	logic [1:0] sclkS_r, selS_r, sinS_r, supS_r;
	logic sclkD_r;
	// Serial state
	srtc_phase_e phase_r, phase_nxt;
	logic [3:0] bits_r, bits_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] outSh_r, outSh_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic outEn_r, outEn_nxt, sout_r, sout_nxt;
	logic wrStb_r, wrStb_nxt, rdStb_r, rdStb_nxt;
	logic [7:0] wrData_r, wrData_nxt;
	logic load_r, load_nxt, freeze_r, freeze_nxt;
	logic active_r, active_nxt;
	// Recovery counter and reset output
	logic [31:0] rec_r, rec_nxt;
	logic rstEn_r, rstEn_nxt;
	// Edge terms from synchronised pins
	logic rise, fall, sel, sin, sup;

	assign sel = ~selS_r[1] & sup;
	assign sin = sinS_r[1];
	assign sup = supS_r[1];
	assign rise = sclkS_r[1] & ~sclkD_r;
	assign fall = ~sclkS_r[1] & sclkD_r;

	// Serial next-state logic
	always_comb begin
		phase_nxt = phase_r;
		bits_nxt = bits_r;
		shift_nxt = shift_r;
		outSh_nxt = outSh_r;
		addr_nxt = addr_r;
		outEn_nxt = outEn_r;
		sout_nxt = sout_r;
		wrStb_nxt = 1'b0;
		rdStb_nxt = 1'b0;
		wrData_nxt = wrData_r;
		load_nxt = 1'b0;
		active_nxt = active_r;
		freeze_nxt = freeze_r;
		if (!sup) begin
			// Abort and clear pointer on supply loss
			phase_nxt = SRTC_CMD; // see (R16)
			bits_nxt = BITS_RST;
			addr_nxt = ADDR_RST; // see (R16)
			outEn_nxt = 1'b0;
			active_nxt = 1'b0;
			freeze_nxt = 1'b0;
		end else if (!sel) begin
			// Deselected: restart, release output, resume copy
			phase_nxt = SRTC_CMD; // see (R20)
			bits_nxt = BITS_RST; // see (R04)
			outEn_nxt = 1'b0; // see (R04)
			active_nxt = 1'b0;
			freeze_nxt = 1'b0; // see (R15)
		end else begin
			active_nxt = 1'b1; // see (R18)
			if (rise && active_r) begin
				// Sample input MSB first on rising edge
				shift_nxt = {shift_r[6:0], sin}; // see (R01) see (R06)
				bits_nxt = bits_r + 4'h1; // see (R10)
				if (bits_r == 4'(BYTE_BITS - 1)) begin
					bits_nxt = BITS_RST;
					if (phase_r == SRTC_CMD) begin
						// Direction, then 7-bit address with bit 6 dropped
						addr_nxt = {shift_r[4:0], sin}; // see (R08) see (R09)
						if (shift_r[6] == DIR_WRITE) begin // see (R07)
							phase_nxt = SRTC_WR;
						end else begin
							phase_nxt = SRTC_RD;
							rdStb_nxt = 1'b1;
						end
					end else if (phase_r == SRTC_WR) begin
						// Complete written byte; pointer moves after strobe
						wrData_nxt = {shift_r[6:0], sin};
						wrStb_nxt = 1'b1;
						load_nxt = (addr_r <= CLOCK_LAST); // see (R19)
					end else begin
						// Read byte finished, advance and fetch next
						addr_nxt = (addr_r == ADDR_TOP) ? ADDR_RST
							: addr_r + 6'h01; // see (R11) see (R12)
						rdStb_nxt = 1'b1;
					end
				end
			end
			// Advance only after the strobe, so the write lands where aimed
			if (wrStb_r) begin
				addr_nxt = (addr_r == ADDR_TOP) ? ADDR_RST
					: addr_r + 6'h01; // see (R11) see (R12)
			end
			if (fall && phase_r == SRTC_RD) begin
				// Shift next bit out after falling edge
				outEn_nxt = 1'b1; // see (R13)
				sout_nxt = outSh_r[7]; // see (R02)
				outSh_nxt = {outSh_r[6:0], 1'b0};
			end
			// Freeze while pointer sits on a clock location
			freeze_nxt = (phase_r != SRTC_CMD)
				&& (addr_r <= CLOCK_LAST); // see (R14) see (R15)
		end
		// Load full byte one cycle after fetch strobe
		if (rdStb_r) begin
			outSh_nxt = regRdData; // see (R13)
		end
	end

	// Recovery timing for the reset output
	always_comb begin
		rec_nxt = rec_r;
		rstEn_nxt = rstEn_r;
		if (!sup) begin
			rec_nxt = 32'(RECOVER); // see (R17)
			rstEn_nxt = 1'b1;
		end else if (rec_r != 32'h0000_0000) begin
			rec_nxt = rec_r - 32'h0000_0001;
			rstEn_nxt = 1'b1; // see (R17)
		end else begin
			rstEn_nxt = 1'b0;
		end
	end

	// Registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sclkS_r <= 2'b00;
			selS_r <= 2'b11;
			sinS_r <= 2'b00;
			supS_r <= 2'b00;
			sclkD_r <= 1'b0;
			phase_r <= SRTC_CMD;
			bits_r <= BITS_RST;
			shift_r <= 8'h00;
			outSh_r <= 8'h00;
			addr_r <= ADDR_RST;
			outEn_r <= 1'b0;
			sout_r <= 1'b0;
			wrStb_r <= 1'b0;
			rdStb_r <= 1'b0;
			wrData_r <= 8'h00;
			load_r <= 1'b0;
			freeze_r <= 1'b0;
			active_r <= 1'b0;
			rec_r <= 32'(RECOVER);
			rstEn_r <= 1'b1;
		end else begin
			sclkS_r <= {sclkS_r[0], link.sclk};
			selS_r <= {selS_r[0], link.selN};
			sinS_r <= {sinS_r[0], link.serial_in_line};
			supS_r <= {supS_r[0], supplyOk};
			sclkD_r <= sclkS_r[1];
			phase_r <= phase_nxt;
			bits_r <= bits_nxt;
			shift_r <= shift_nxt;
			outSh_r <= outSh_nxt;
			addr_r <= addr_nxt;
			outEn_r <= outEn_nxt;
			sout_r <= sout_nxt;
			wrStb_r <= wrStb_nxt;
			rdStb_r <= rdStb_nxt;
			wrData_r <= wrData_nxt;
			load_r <= load_nxt;
			freeze_r <= freeze_nxt;
			active_r <= active_nxt;
			rec_r <= rec_nxt;
			rstEn_r <= rstEn_nxt;
		end
	end

	// Outputs straight from flip-flops
	assign link.serial_out_line = sout_r;
	assign link.serialOutEn = outEn_r;
	assign link.rstOutEn = rstEn_r;
	assign regAddr = addr_r;
	assign regWrData = wrData_r;
	assign regWrStb = wrStb_r;
	assign regRdStb = rdStb_r;
	assign freezeCopy = freeze_r;
	assign clockLoad = load_r;
endmodule : srtc_device

// ===== srtc_pkg.sv
// Shared constants and types for the serial clock-chip register link
package srtc_pkg;
	// Bits in one serial group
	localparam int unsigned BYTE_BITS = 8;
	// Address pointer width and wrap point
	localparam int unsigned ADDR_W = 6;
	localparam logic [5:0] ADDR_TOP = 6'h3F;
	localparam logic [5:0] ADDR_RST = 6'h00;
	// Last clock location; clock locations are 00h..07h
	localparam logic [5:0] CLOCK_LAST = 6'h07;
	// Direction bit values
	localparam logic DIR_WRITE = 1'b1;
	localparam logic DIR_READ = 1'b0;
	// Reset output recovery time and cycles at 10 MHz
	localparam int unsigned RECOVER_MS = 210;
	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned RECOVER_CYC = RECOVER_MS * (CLK_HZ / 1000);
	// Host serial clock divider: half period in core cycles
	localparam int unsigned HALF_CYC = 4;
	// Bit counter reset value
	localparam logic [3:0] BITS_RST = 4'h0;
	// Device serial phase
	typedef enum logic [1:0] {SRTC_CMD, SRTC_WR, SRTC_RD} srtc_phase_e;
	// Host sequencer state
	typedef enum logic [1:0] {SRTC_IDLE, SRTC_LOW, SRTC_HIGH, SRTC_END}
		srtc_host_e;
endpackage : srtc_pkg

// ===== srtc_if.sv
// Serial link between the clock chip and its host master
`timescale 1ns/1ps
interface srtc_if;
	// Serial clock from the master
	logic sclk;
	// Active-low select from the master
	logic selN;
	// Serial data toward the device
	logic serial_in_line;
	// Serial data from the device, with its enable
	logic serial_out_line;
	logic serialOutEn;
	// Open-drain reset output: low while enable is high
	logic rstOutEn;
	modport device (input sclk, input selN, input serial_in_line,
		output serial_out_line, output serialOutEn, output rstOutEn);
	modport host (output sclk, output selN, output serial_in_line,
		input serial_out_line, input serialOutEn, input rstOutEn);
endinterface : srtc_if

// ===== srtc_host.sv
// Host end: serial master issuing register transfers
`timescale 1ns/1ps
module srtc_host (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Serial link
	srtc_if.host link,
	// User request: command byte then data bytes
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [6:0] reqAddr,
	input wire logic [7:0] reqData,
	input wire logic reqLast,
	output logic reqReady,
	// Read answer and frame busy flag
	output logic [7:0] rspData,
	output logic rspValid,
	output logic busy
);
	import srtc_pkg::*;

	// Sequencer state
	srtc_host_e st_r, st_nxt;
	logic [3:0] bits_r, bits_nxt;
	logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt, rsp_r, rsp_nxt;
	logic [2:0] div_r, div_nxt;
	logic cmd_r, cmd_nxt, last_r, last_nxt;
	logic sclk_r, sclk_nxt, sel_r, sel_nxt, sdo_r, sdo_nxt;
	logic rdy_r, rdy_nxt, rv_r, rv_nxt, rd_r, rd_nxt;
	// Synchronised device output
	logic [1:0] sinS_r;

	// Mode 0,0 master: clock idles low, data set while low
	always_comb begin
		st_nxt = st_r;
		bits_nxt = bits_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		rsp_nxt = rsp_r;
		div_nxt = div_r + 3'h1;
		cmd_nxt = cmd_r;
		last_nxt = last_r;
		sclk_nxt = sclk_r;
		sel_nxt = sel_r;
		sdo_nxt = sdo_r;
		rdy_nxt = 1'b0;
		rv_nxt = 1'b0;
		rd_nxt = rd_r;
		case (st_r)
			SRTC_IDLE: begin
				sel_nxt = 1'b1;
				sclk_nxt = 1'b0;
				if (reqValid && !rdy_r) begin
					// Lower select, load command byte
					sel_nxt = 1'b0; // see (R05)
					tx_nxt = {reqWrite, reqAddr}; // see (R07)
					rd_nxt = !reqWrite;
					cmd_nxt = 1'b1;
					last_nxt = 1'b0;
					rdy_nxt = 1'b1;
					bits_nxt = BITS_RST;
					div_nxt = 3'h0;
					st_nxt = SRTC_LOW;
				end
			end
			SRTC_LOW: begin
				sdo_nxt = tx_r[7]; // see (R06)
				if (div_r == 3'(HALF_CYC - 1)) begin
					sclk_nxt = 1'b1; // see (R03)
					div_nxt = 3'h0;
					st_nxt = SRTC_HIGH;
				end
			end
			SRTC_HIGH: begin
				if (div_r == 3'(HALF_CYC - 1)) begin
					sclk_nxt = 1'b0;
					div_nxt = 3'h0;
					tx_nxt = {tx_r[6:0], 1'b0};
					rx_nxt = {rx_r[6:0], sinS_r[1]};
					bits_nxt = bits_r + 4'h1; // see (R10)
					st_nxt = SRTC_LOW;
					if (bits_r == 4'(BYTE_BITS - 1)) begin
						bits_nxt = BITS_RST;
						if (!cmd_r && rd_r) begin
							rsp_nxt = {rx_r[6:0], sinS_r[1]};
							rv_nxt = 1'b1;
						end
						if (last_r || (cmd_r && reqLast && !reqValid)) begin
							st_nxt = SRTC_END;
						end else if (reqValid) begin
							// Next data byte of the burst
							tx_nxt = reqData;
							last_nxt = reqLast;
							rdy_nxt = 1'b1;
						end else begin
							st_nxt = SRTC_END;
						end
						cmd_nxt = 1'b0;
					end
				end
			end
			default: begin
				// Raise select to end the burst
				sel_nxt = 1'b1;
				st_nxt = SRTC_IDLE;
			end
		endcase
	end

	// Registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_r <= SRTC_IDLE;
			bits_r <= BITS_RST;
			tx_r <= 8'h00;
			rx_r <= 8'h00;
			rsp_r <= 8'h00;
			div_r <= 3'h0;
			cmd_r <= 1'b0;
			last_r <= 1'b0;
			sclk_r <= 1'b0;
			sel_r <= 1'b1;
			sdo_r <= 1'b0;
			rdy_r <= 1'b0;
			rv_r <= 1'b0;
			rd_r <= 1'b0;
			sinS_r <= 2'b00;
		end else begin
			st_r <= st_nxt;
			bits_r <= bits_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			rsp_r <= rsp_nxt;
			div_r <= div_nxt;
			cmd_r <= cmd_nxt;
			last_r <= last_nxt;
			sclk_r <= sclk_nxt;
			sel_r <= sel_nxt;
			sdo_r <= sdo_nxt;
			rdy_r <= rdy_nxt;
			rv_r <= rv_nxt;
			rd_r <= rd_nxt;
			sinS_r <= {sinS_r[0], link.serial_out_line};
		end
	end

	// Outputs from flip-flops
	assign link.sclk = sclk_r;
	assign link.selN = sel_r;
	assign link.serial_in_line = sdo_r;
	assign reqReady = rdy_r;
	assign rspData = rsp_r;
	assign rspValid = rv_r;
	assign busy = ~sel_r;
endmodule : srtc_host

// ===== srtc_monitor.sv
// Protocol checker watching the serial clock-chip link
`timescale 1ns/1ps
module srtc_monitor #(
	parameter int unsigned RECOVER = srtc_pkg::RECOVER_CYC
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Link signals
	input wire logic sclk,
	input wire logic selN,
	input wire logic serial_in_line,
	input wire logic serial_out_line,
	input wire logic serialOutEn,
	input wire logic rstOutEn
);
	// Last serial clock level and rise strobe
	logic sclkQ_r, rise;
	// Rises seen in this select period
	logic [7:0] riseCnt_r, riseCnt_nxt;
	// Direction bit of this select period
	logic dirBit_r, dirBit_nxt;
	// Cycles the reset output has been held
	int unsigned hiCnt_r, hiCnt_nxt;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// Next values of the tracking state
	always_comb begin
		rise = sclk && !sclkQ_r;
		riseCnt_nxt = riseCnt_r;
		dirBit_nxt = dirBit_r;
		hiCnt_nxt = rstOutEn ? hiCnt_r + 1 : 0;
		// Deselect restarts the count
		if (selN) begin
			riseCnt_nxt = 8'h00;
		end else if (rise) begin
			riseCnt_nxt = riseCnt_r + 8'h01;
			// First bit of the frame sets direction
			if (riseCnt_r == 8'h00) begin
				dirBit_nxt = serial_in_line;
			end
		end
	end
	// Tracking registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sclkQ_r <= 1'b0;
			riseCnt_r <= 8'h00;
			dirBit_r <= 1'b0;
			hiCnt_r <= 0;
		end else begin
			sclkQ_r <= sclk;
			riseCnt_r <= riseCnt_nxt;
			dirBit_r <= dirBit_nxt;
			hiCnt_r <= hiCnt_nxt;
		end
	end
	a_idle_released: assert property (
		selN [*4] |-> !serialOutEn)
		else $error("output driven while deselected");
	a_shift_on_fall: assert property (
		serialOutEn && $past(serialOutEn) && $changed(serial_out_line)
		|-> !sclk)
		else $error("output bit moved while clock high");
	a_enable_at_fall: assert property (
		$rose(serialOutEn) |-> !sclk && !selN)
		else $error("output enabled outside a low clock phase");
	a_clock_idle_low: assert property (selN |-> !sclk)
		else $error("serial clock high while deselected");
	a_whole_bytes: assert property (
		$rose(selN) |-> riseCnt_r[2:0] == 3'h0)
		else $error("frame ended inside a byte");
	a_recover_hold: assert property (
		$fell(rstOutEn) |-> hiCnt_r >= RECOVER)
		else $error("reset output released early");
	a_byte_first: assert property (
		serialOutEn && !selN |-> riseCnt_r >= 8'h08)
		else $error("output driven before command byte done");
	a_read_only: assert property (
		serialOutEn && !selN |-> !dirBit_r)
		else $error("output driven in a write frame");
endmodule : srtc_monitor

// ===== tb_top.sv
// Self-checking bench joining the host and device ends
`timescale 1ns/1ps
module tb_top;
	import srtc_pkg::*;
	// Shortened recovery time and run ceiling
	localparam int unsigned RECOV = 20;
	localparam int LIMIT = 20000;
	// Clock, reset and supply
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic supplyOk = 1'b1;
	// Host request side
	logic reqValid = 1'b0;
	logic reqWrite = 1'b0;
	logic [6:0] reqAddr = 7'h00;
	logic [7:0] reqData = 8'h00;
	logic reqLast = 1'b0;
	logic reqReady, rspValid, busy;
	logic [7:0] rspData;
	// Device register port and timekeeping outputs
	logic [ADDR_W-1:0] regAddr;
	logic [7:0] regWrData, regRdData;
	logic regWrStb, freezeCopy, clockLoad;
	// Bookkeeping
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	int k, n;
	logic frz = 1'b0;
	logic [14:0] wrQ[$];
	logic [7:0] rdQ[$];
	logic [7:0] dBuf[0:7];
	srtc_if link();
	srtc_device #(.RECOVER(RECOV)) srtc_device_inst (.core_clk(core_clk),
		.rst(rst), .link(link), .supplyOk(supplyOk), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(),
		.regRdData(regRdData), .freezeCopy(freezeCopy), .clockLoad(clockLoad));
	srtc_host srtc_host_inst (.core_clk(core_clk), .rst(rst), .link(link),
		.reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
		.reqData(reqData), .reqLast(reqLast), .reqReady(reqReady),
		.rspData(rspData), .rspValid(rspValid), .busy(busy));
	srtc_monitor #(.RECOVER(RECOV)) srtc_monitor_inst (.core_clk(core_clk),
		.rst(rst), .sclk(link.sclk), .selN(link.selN),
		.serial_in_line(link.serial_in_line),
		.serial_out_line(link.serial_out_line),
		.serialOutEn(link.serialOutEn), .rstOutEn(link.rstOutEn));
	// Register contents seen by reads
	function automatic logic [7:0] reg_val(input logic [5:0] ad);
		return {ad, 2'b10} ^ 8'h3C;
	endfunction : reg_val
	assign regRdData = reg_val(regAddr);
	always #50 core_clk = ~core_clk;
	// Collect strobes and results, cut a hang short
	always @(posedge core_clk) begin
		cyc++;
		if (regWrStb === 1'b1)
			wrQ.push_back({clockLoad, regAddr, regWrData});
		if (rspValid === 1'b1)
			rdQ.push_back(rspData);
		if (freezeCopy === 1'b1)
			frz = 1'b1;
		if (cyc > LIMIT) begin
			err_total++;
			$display("MISMATCH t=%0t run ceiling reached", $time);
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t byte %h expected %h", $time, got, exp);
		end
	endtask : chk_byte
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	// One frame: command then cnt data bytes
	task automatic xfer(input logic w, input logic [6:0] ad, input int cnt);
		int i;
		wrQ.delete();
		rdQ.delete();
		frz = 1'b0;
		for (i = 0; i <= cnt; i++) begin
			reqValid <= 1'b1;
			reqWrite <= w;
			reqAddr <= ad;
			reqData <= (i == 0) ? 8'h00 : dBuf[i-1];
			reqLast <= (i == cnt);
			do
				@(posedge core_clk);
			while (reqReady !== 1'b1);
		end
		reqValid <= 1'b0;
		reqLast <= 1'b0;
		do
			@(posedge core_clk);
		while (busy !== 1'b0);
		repeat (6) @(posedge core_clk);
	endtask : xfer
	// Frame plus comparison of strobes, read bytes and freeze
	task automatic run(input logic w, input logic [6:0] ad, input int cnt,
		input string name);
		int i;
		logic [5:0] ea;
		logic ef;
		xfer(w, ad, cnt);
		ef = 1'b0;
		chk_byte(8'(w ? wrQ.size() : rdQ.size()), 8'(cnt));
		for (i = 0; i < cnt; i++) begin
			ea = ad[5:0] + 6'(i);
			ef = ef | (ea <= CLOCK_LAST);
			if (w && i < wrQ.size()) begin
				chk_byte({2'b00, wrQ[i][13:8]}, {2'b00, ea});
				chk_byte(wrQ[i][7:0], dBuf[i]);
				chk_bit(wrQ[i][14], ea <= CLOCK_LAST);
			end else if (!w && i < rdQ.size()) begin
				chk_byte(rdQ[i], reg_val(ea));
			end
		end
		// Pointer parked on a clock address at the end may freeze briefly
		if (ad[5:0] + 6'(cnt) > CLOCK_LAST)
			chk_bit(frz, ef);
		chk_bit(freezeCopy, 1'b0);
		$display("test %s done", name);
	endtask : run
	// Main sequence
	initial begin
		void'($urandom(32'h7df6_2201));
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk_bit(link.rstOutEn, 1'b1);
		repeat (RECOV + 8) @(posedge core_clk);
		chk_bit(link.rstOutEn, 1'b0);
		$display("test recovery done");
		for (k = 0; k < 8; k++)
			dBuf[k] = 8'($urandom());
		run(1'b1, 7'h7E, 3, "write wrap");
		run(1'b0, 7'h45, 4, "read clock");
		run(1'b0, 7'h10, 1, "read plain");
		for (k = 0; k < 6; k++) begin
			for (n = 0; n < 8; n++)
				dBuf[n] = 8'($urandom());
			run(1'($urandom()), 7'($urandom()), int'($urandom_range(4, 1)),
				"random");
		end
		dBuf[0] = 8'hC3;
		fork
			xfer(1'b1, 7'h12, 1);
			begin
				repeat (20) @(posedge core_clk);
				supplyOk <= 1'b0;
			end
		join
		chk_byte(8'(wrQ.size()), 8'h00);
		chk_bit(link.rstOutEn, 1'b1);
		supplyOk <= 1'b1;
		repeat (5) @(posedge core_clk);
		chk_bit(link.rstOutEn, 1'b1);
		$display("test supply cut done");
		run(1'b1, 7'h12, 1, "after supply");
		chk_bit(link.rstOutEn, 1'b0);
		print_verdict();
	end
endmodule : tb_top
